/* compare_move_unit.sv */
// compare and move execution datapath
// Summary of operation
// - three-way compare writes outcome to flags
// - operands signed; sign bit 15 or 31
// - flags: above, equal, below in order
// - exactly one flag set per compare
// - undriven three-way compare keeps its flags
// - zone compare tests value against two bounds
// - flags: below lower, inside, above upper
// - inverted bounds: compare against lower bound
// - undriven zone compare keeps its flags
// - indexed operands allow only 16-bit form
// - move copies unchanged; idle keeps destination
// - word move transfers one 16-bit word
// - double move: upper word from higher register in 32-bit form, zero in 16-bit form
module compare_move_unit (
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    input  wire logic                drive,
    input  wire cmp_move_pkg::op_t   op,
    input  wire logic                wide,
    input  wire logic                indexed,
    input  wire logic [31:0]         src1,
    input  wire logic [31:0]         src2,
    input  wire logic [31:0]         src3,
    input  wire logic [15:0]         src_low,
    input  wire logic [15:0]         src_high,
    output logic [2:0]               cmp_flags,
    output logic [2:0]               zone_flags,
    output logic [31:0]              dest,
    output logic                     done,
    output logic                     form_error
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [2:0]  cmp_flags;
        logic [2:0]  zone_flags;
        logic [31:0] dest;
        logic        done;
        logic        form_error;
    } state_t;

    state_t st;
    state_t next_st;

    // ************************************************************
    // comparators
    // ************************************************************
    // lo_if carries the main compare and the lower-bound test, hi_if the upper one
    cmp_move_if lo_if ();
    cmp_move_if hi_if ();

    signed_comparator u_lo (
        .cmp (lo_if.comparator)
    );
    signed_comparator u_hi (
        .cmp (hi_if.comparator)
    );

    logic               eff_wide;
    logic               bounds_inverted;
    logic signed [31:0] lo_s;
    logic signed [31:0] hi_s;
    logic               cmp_hit;
    logic               zone_hit;
    logic               move_hit;
    logic               known_op;
    logic [2:0]         zone_result;
    logic [31:0]        move_result;

    // ************************************************************
    // operation decode
    // ************************************************************
    always_comb begin
        cmp_hit  = 1'b0;
        zone_hit = 1'b0;
        move_hit = 1'b0;
        known_op = 1'b1;
        case (op)
            cmp_move_pkg::OP_THREE_WAY_COMPARE: begin
                cmp_hit = drive;
            end
            cmp_move_pkg::OP_ZONE_COMPARE: begin
                zone_hit = drive;
            end
            cmp_move_pkg::OP_WORD_MOVE: begin
                move_hit = drive;
            end
            cmp_move_pkg::OP_DOUBLE_WORD_MOVE: begin
                move_hit = drive;
            end
            default: begin
                // digit shift move is decoded only, so it writes no result and done stays low
                known_op = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // width selection
    // ************************************************************
    always_comb begin
        // indexed operands force the narrow form
        eff_wide = wide & ~indexed;
        if (eff_wide) begin
            lo_s = src1;
            hi_s = src2;
        end else begin
            lo_s = {{16{src1[15]}}, src1[15:0]};
            hi_s = {{16{src2[15]}}, src2[15:0]};
        end
        bounds_inverted = (lo_s > hi_s);
    end

    // ************************************************************
    // comparator operands
    // ************************************************************
    always_comb begin
        lo_if.wide = eff_wide;
        hi_if.wide = eff_wide;
        if (op == cmp_move_pkg::OP_ZONE_COMPARE) begin
            // lower bound against the value, value against the upper bound
            lo_if.lhs = src1;
            lo_if.rhs = src3;
            hi_if.lhs = src3;
            hi_if.rhs = src2;
        end else begin
            lo_if.lhs = src1;
            lo_if.rhs = src2;
            // upper comparator idles on zeros outside the zone compare
            hi_if.lhs = 32'h0000_0000;
            hi_if.rhs = 32'h0000_0000;
        end
    end

    // ************************************************************
    // zone decision
    // ************************************************************
    always_comb begin
        zone_result = cmp_move_pkg::FLAG_RESET;
        if (bounds_inverted) begin
            // lower bound alone acts as the reference
            zone_result = lo_if.flags;
        end else if (lo_if.flags[cmp_move_pkg::FLAG_ABOVE]) begin
            // zone group reuses the bit positions of the three-way group
            zone_result[cmp_move_pkg::FLAG_ABOVE] = 1'b1;
        end else if (hi_if.flags[cmp_move_pkg::FLAG_ABOVE]) begin
            zone_result[cmp_move_pkg::FLAG_BELOW] = 1'b1;
        end else begin
            // both bounds count as inside
            zone_result[cmp_move_pkg::FLAG_EQUAL] = 1'b1;
        end
    end

    // ************************************************************
    // move data
    // ************************************************************
    always_comb begin
        move_result = st.dest;
        if (op == cmp_move_pkg::OP_DOUBLE_WORD_MOVE) begin
            if (eff_wide) begin
                move_result = {src_high, src_low};
            end else begin
                // narrow form of the pair moves the low word only
                move_result = {16'h0000, src_low};
            end
        end else if (op == cmp_move_pkg::OP_WORD_MOVE) begin
            move_result = {16'h0000, src1[15:0]};
        end
    end

    // ************************************************************
    // execution
    // ************************************************************
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        // undriven or digit shift cycles leave form_error as it was
        if (drive && known_op) begin
            next_st.done       = 1'b1;
            next_st.form_error = wide & indexed;
        end
        // each group is written whole, so the two losing flags drop together
        if (cmp_hit) begin
            next_st.cmp_flags = lo_if.flags;
        end
        if (zone_hit) begin
            next_st.zone_flags = zone_result;
        end
        if (move_hit) begin
            next_st.dest = move_result;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        // reset loads constants only
        if (!rstn) begin
            st.cmp_flags  <= cmp_move_pkg::FLAG_RESET;
            st.zone_flags <= cmp_move_pkg::FLAG_RESET;
            st.dest       <= cmp_move_pkg::DEST_RESET;
            st.done       <= 1'b0;
            st.form_error <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // every output comes straight from a flip-flop
    assign cmp_flags  = st.cmp_flags;
    assign zone_flags = st.zone_flags;
    assign dest       = st.dest;
    assign done       = st.done;
    assign form_error = st.form_error;
endmodule : compare_move_unit

/* cmp_move_pkg.sv */
// package: operation codes, widths and reset values for the compare/move unit
package cmp_move_pkg;

    // ************************************************************
    // operation select
    // ************************************************************
    typedef enum logic [2:0] {
        OP_THREE_WAY_COMPARE,
        OP_ZONE_COMPARE,
        OP_WORD_MOVE,
        OP_DOUBLE_WORD_MOVE,
        OP_DIGIT_SHIFT_MOVE
    } op_t;

    // ************************************************************
    // widths and reset values
    // ************************************************************
    localparam int          WORD_W       = 16;
    localparam int          DWORD_W      = 32;
    localparam int          FLAG_N       = 3;
    localparam logic [2:0]  FLAG_RESET   = 3'h0;
    localparam logic [31:0] DEST_RESET   = 32'h0000_0000;

    // ************************************************************
    // flag positions within the three-flag group
    // ************************************************************
    localparam int FLAG_ABOVE = 0;
    localparam int FLAG_EQUAL = 1;
    localparam int FLAG_BELOW = 2;

endpackage : cmp_move_pkg

/* cmp_move_if.sv */
// interface: carries a signed comparison request and its three-flag answer
interface cmp_move_if;
    logic        wide;
    logic [31:0] lhs;
    logic [31:0] rhs;
    logic [2:0]  flags;

    modport requester (output wide, output lhs, output rhs, input flags);
    modport comparator (input wide, input lhs, input rhs, output flags);
endinterface : cmp_move_if

/* signed_comparator.sv */
// signed three-way comparator for 16- or 32-bit operands
module signed_comparator (
    cmp_move_if.comparator cmp
);
    logic signed [31:0] a;
    logic signed [31:0] b;

    always_comb begin
        // narrow form sign-extends from bit 15
        if (cmp.wide) begin
            a = cmp.lhs;
            b = cmp.rhs;
        end else begin
            a = {{16{cmp.lhs[15]}}, cmp.lhs[15:0]};
            b = {{16{cmp.rhs[15]}}, cmp.rhs[15:0]};
        end
        cmp.flags = 3'h0;
        if (a > b) begin
            cmp.flags[cmp_move_pkg::FLAG_ABOVE] = 1'b1;
        end else if (a == b) begin
            cmp.flags[cmp_move_pkg::FLAG_EQUAL] = 1'b1;
        end else begin
            cmp.flags[cmp_move_pkg::FLAG_BELOW] = 1'b1;
        end
    end
endmodule : signed_comparator

/* cmu_props.sv */
// checker: port-level properties of the compare/move unit
module cmu_props (
    input wire logic ref_clk, rstn, drive, wide, indexed, done, form_error,
    input wire cmp_move_pkg::op_t op,
    input wire logic [31:0] src1, src2, src3, dest,
    input wire logic [15:0] src_low, src_high,
    input wire logic [2:0] cmp_flags, zone_flags
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    function automatic logic signed [31:0] ext(input logic w, input logic [31:0] x);
        return w ? x : {{16{x[15]}}, x[15:0]};
    endfunction : ext
    function automatic logic [2:0] ord(input logic signed [31:0] a, b);
        return {a < b, a == b, a > b};
    endfunction : ord
    // indexed operands fall back to the 16-bit form
    wire logic w = wide && !indexed;
    wire logic signed [31:0] lo = ext(w, src1), hi = ext(w, src2), v = ext(w, src3);
    wire logic [2:0] e_zone = lo > hi ? ord(lo, v) : {v > hi, v >= lo && v <= hi, lo > v};
    wire logic run_c = drive && op == 3'h0, run_z = drive && op == 3'h1;
    wire logic run_m = drive && op == 3'h2, run_d = drive && op == 3'h3;
    wire logic run_any = run_c || run_z || run_m || run_d;
    cmp_result_a: assert property (run_c |=> cmp_flags == $past(ord(lo, hi)))
        else $error("cmp flags");
    zone_result_a: assert property (run_z |=> zone_flags == $past(e_zone))
        else $error("zone flags");
    one_hot_a: assert property (run_c |=> $onehot(cmp_flags))
        else $error("cmp not one hot");
    cmp_hold_a: assert property (!run_c |=> $stable(cmp_flags))
        else $error("cmp flags moved");
    zone_hold_a: assert property (!run_z |=> $stable(zone_flags))
        else $error("zone flags moved");
    word_move_a: assert property (run_m |=> dest == {16'h0000, $past(src1[15:0])})
        else $error("word move");
    dword_move_a: assert property (run_d |=>
        dest == $past(w ? {src_high, src_low} : {16'h0000, src_low}))
        else $error("double move");
    dest_hold_a: assert property (!(run_m || run_d) |=> $stable(dest))
        else $error("dest moved");
    done_pulse_a: assert property (run_any |=> done)
        else $error("done missing");
    done_idle_a: assert property (!run_any |=> !done)
        else $error("done without execution");
    form_flag_a: assert property (run_any |=> form_error == $past(wide && indexed))
        else $error("form flag");
    form_hold_a: assert property (!run_any |=> $stable(form_error))
        else $error("form flag moved");
endmodule : cmu_props

/* seq_model.sv */
// partner model: sequencer presenting operands and the drive condition
module seq_model (
    input wire logic ref_clk,
    output cmp_move_pkg::op_t op,
    output logic drive, wide, indexed,
    output logic [31:0] src1, src2, src3,
    output logic [15:0] src_low, src_high
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {drive, wide, indexed, src1, src2, src3, src_low, src_high} = '0;
        op = cmp_move_pkg::OP_THREE_WAY_COMPARE;
    end
    task automatic issue(input logic d, input logic [2:0] o, input logic [1:0] f,
                         input logic [31:0] a, b, c);
        @(negedge ref_clk);
        drive = d;
        op = cmp_move_pkg::op_t'(o);
        {wide, indexed} = f;
        src1 = a;
        src2 = b;
        src3 = c;
        {src_high, src_low} = a;
    endtask : issue
endmodule : seq_model

/* tb_top.sv */
// testbench: directed scenarios for the compare/move unit
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic drive, wide, indexed, done, form_error;
    cmp_move_pkg::op_t op;
    logic [31:0] src1, src2, src3, dest;
    logic [15:0] src_low, src_high;
    logic [2:0] cmp_flags, zone_flags;
    int num_errors = 0;
    int check_count = 0;
    always #10 ref_clk = ~ref_clk;
    seq_model seq (
        .ref_clk  (ref_clk),
        .op       (op),
        .drive    (drive),
        .wide     (wide),
        .indexed  (indexed),
        .src1     (src1),
        .src2     (src2),
        .src3     (src3),
        .src_low  (src_low),
        .src_high (src_high)
    );
    compare_move_unit uut (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .drive      (drive),
        .op         (op),
        .wide       (wide),
        .indexed    (indexed),
        .src1       (src1),
        .src2       (src2),
        .src3       (src3),
        .src_low    (src_low),
        .src_high   (src_high),
        .cmp_flags  (cmp_flags),
        .zone_flags (zone_flags),
        .dest       (dest),
        .done       (done),
        .form_error (form_error)
    );
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // idle slot carries inverted operands so a held result cannot pass by luck
    task automatic step(input logic [2:0] o, input logic [1:0] f, input logic [31:0] a, b, c);
        seq.issue(1'b1, o, f, a, b, c);
        seq.issue(1'b0, o, f, ~a, ~b, ~c);
        chk("done", {31'h0, o != 3'h4}, done);
        @(negedge ref_clk);
        chk("done", 32'h0, done);
    endtask : step
    task automatic close_out;
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    task automatic t_compare;
        step(3'h0, 2'h0, 32'h5, 32'h3, 32'h0);
        chk("cmp", 32'h1, cmp_flags);
        step(3'h0, 2'h0, 32'h8000, 32'h1, 32'h0);
        chk("cmp", 32'h4, cmp_flags);
        step(3'h0, 2'h2, 32'h8000_0000, 32'h7FFF_FFFF, 32'h0);
        chk("cmp", 32'h4, cmp_flags);
        step(3'h0, 2'h3, 32'h1_8000, 32'h1, 32'h0);
        chk("cmp", 32'h4, cmp_flags);
        chk("form", 32'h1, form_error);
        step(3'h0, 2'h0, 32'h7, 32'h7, 32'h0);
        chk("cmp", 32'h2, cmp_flags);
    endtask : t_compare
    task automatic t_zone;
        step(3'h1, 2'h0, 32'hFFFE, 32'h5, 32'hFFFD);
        chk("zone", 32'h1, zone_flags);
        step(3'h1, 2'h0, 32'hFFFE, 32'h5, 32'h5);
        chk("zone", 32'h2, zone_flags);
        step(3'h1, 2'h0, 32'hFFFE, 32'h5, 32'h6);
        chk("zone", 32'h4, zone_flags);
        step(3'h1, 2'h2, 32'h8000_0000, 32'h7FFF_FFFF, 32'h0001_8000);
        chk("zone", 32'h2, zone_flags);
        step(3'h1, 2'h0, 32'h5, 32'hFFFE, 32'h9);
        chk("zone", 32'h4, zone_flags);
        chk("cmp", 32'h2, cmp_flags);
    endtask : t_zone
    task automatic t_move;
        step(3'h2, 2'h0, 32'hABCD_1234, 32'h0, 32'h0);
        chk("dest", 32'h1234, dest);
        step(3'h3, 2'h3, 32'h1357_2468, 32'h0, 32'h0);
        chk("dest", 32'h2468, dest);
        chk("form", 32'h1, form_error);
        step(3'h3, 2'h2, 32'h8765_4321, 32'h0, 32'h0);
        chk("dest", 32'h8765_4321, dest);
        chk("form", 32'h0, form_error);
        step(3'h4, 2'h0, 32'h1, 32'h2, 32'h3);
        chk("dest", 32'h8765_4321, dest);
        chk("zone", 32'h4, zone_flags);
    endtask : t_move
    // mid-run reset is the bench's own clear of both flag groups
    task automatic t_reset;
        step(3'h0, 2'h0, 32'h1, 32'h2, 32'h0);
        rstn = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("cmp", {29'h0, cmp_move_pkg::FLAG_RESET}, cmp_flags);
        chk("zone", {29'h0, cmp_move_pkg::FLAG_RESET}, zone_flags);
        chk("dest", cmp_move_pkg::DEST_RESET, dest);
        chk("form", 32'h0, form_error);
        rstn = 1'b1;
        step(3'h0, 2'h0, 32'h2, 32'h2, 32'h0);
        chk("cmp", 32'h2, cmp_flags);
    endtask : t_reset
    initial begin
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        rstn = 1'b1;
        t_compare();
        t_zone();
        t_move();
        t_reset();
        close_out();
    end
    initial begin
        repeat (500) @(posedge ref_clk);
        num_errors++;
        close_out();
    end
endmodule : tb_top
bind compare_move_unit cmu_props props_i (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .drive      (drive),
    .wide       (wide),
    .indexed    (indexed),
    .done       (done),
    .form_error (form_error),
    .op         (op),
    .src1       (src1),
    .src2       (src2),
    .src3       (src3),
    .dest       (dest),
    .src_low    (src_low),
    .src_high   (src_high),
    .cmp_flags  (cmp_flags),
    .zone_flags (zone_flags)
);
